/* File: pkg/fet_sync_regs.svh */
// Offsets, field positions, reset values and timing counts of the FET sync-line controller.
`ifndef FET_SYNC_REGS_SVH
`define FET_SYNC_REGS_SVH

// Register byte offsets.
`define OFS_CTRL        8'h00
`define OFS_BLANK       8'h04
`define OFS_CURREF      8'h08
`define OFS_STATUS      8'h0C

// Control register fields.
`define CTRL_GIO3_FUNC  0
`define CTRL_GIO3_VAL   1
`define CTRL_AUTO_RETRY 2
`define CTRL_FAST_RECOV 3
`define CTRL_ONESHOT    13
`define CTRL_W          14

// Reset values.
`define CTRL_RESET      14'h0000
`define BLANK_RESET     8'h10
`define CURREF_RESET    8'h80

// Condition pin positions.
`define C_EN_OK         0
`define C_EN_SD         1
`define C_VIN_UV        2
`define C_VDD_UV        3
`define C_VIN_OV        4
`define C_OVERTEMP      5
`define C_HEALTH        6
`define C_OVERCURRENT   7
`define C_FAST_TRIP     8
`define C_INRUSH_DONE   9
`define C_OVER_SHARE    10
`define C_SYS_OCP       11
`define COND_W          12

// Timing: clock period and timer tick in ns, phase lengths in ticks.
`define CLK_NS          32'h0000_000A
`define TICK_NS         32'h0000_03E8
`define TICK_CYC        (`TICK_NS / `CLK_NS)
`define INSERT_TICKS    16'h0010
`define RETRY_TICKS     16'h0040
`define FT_OFF_TICKS    16'h0004
`define FT_ON_TICKS     16'h0008

`endif

/* File: pkg/fet_sync_pkg.sv */
// Types shared by the FET sync-line controller and its phase timer.
`include "fet_sync_regs.svh"

package fet_sync_pkg;

  typedef logic [`COND_W-1:0] cond_t;
  typedef logic [15:0]        tcount_t;

  typedef enum logic [3:0] {
    ST_OFF       = 4'b0000,
    ST_INSERT    = 4'b0001,
    ST_INRUSH    = 4'b0010,
    ST_STEADY    = 4'b0011,
    ST_OC_BLANK  = 4'b0100,
    ST_FT_OFF    = 4'b0101,
    ST_FT_ON     = 4'b0110,
    ST_RETRY     = 4'b0111,
    ST_LATCH     = 4'b1000,
    ST_EXT_LATCH = 4'b1001
  } state_t;

  typedef struct packed {
    cond_t              cond_s1;
    cond_t              cond_s2;
    logic               gio_s1;
    logic               gio_s2;
    state_t             state;
    logic               seen_high;
    logic               fet_on;
    logic               pull_oe;
    logic               gio_out;
    logic               acs;
    logic               climit;
    logic [6:0]         div;
    logic               tick;
    logic [`CTRL_W-1:0] ctrl;
    logic [7:0]         blank;
    logic [7:0]         curref;
    logic [7:0]         addr;
    logic               wr_pend;
    logic [31:0]        rdata;
    logic               ready;
  } main_state_t;

  typedef struct packed {
    tcount_t cnt;
    logic    busy;
    logic    done;
  } timer_state_t;

endpackage : fet_sync_pkg

/* File: pkg/timer_if.sv */
// Interface between the controller and its phase timer.
`timescale 1ns/1ns

interface timer_if;
  logic                 start;
  fet_sync_pkg::tcount_t load;
  logic                 tick;
  logic                 done;
  logic                 busy;

  modport ctl (output start, output load, output tick, input done, input busy);
  modport cnt (input start, input load, input tick, output done, output busy);
endinterface : timer_if

/* File: hw/tick_timer.sv */
// Phase timer that counts tick enables down and pulses done once.
`timescale 1ns/1ns

module tick_timer (
  input wire logic hclk,
  input wire logic hresetn,
  timer_if.cnt     tmr
);
  import fet_sync_pkg::*;

  timer_state_t r;
  timer_state_t n;

  // A start reloads the count; each tick decrements it until it expires.
  always_comb begin
    n      = r;
    n.done = 1'b0;
    if (tmr.start) begin
      n.cnt  = tmr.load;
      n.busy = 1'b1;
    end else if (r.busy && tmr.tick) begin
      if (r.cnt <= 16'h0001) begin
        n.cnt  = 16'h0000;
        n.busy = 1'b0;
        n.done = 1'b1;
      end else begin
        n.cnt = r.cnt - 16'h0001;
      end
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tmr.done = r.done;
  assign tmr.busy = r.busy;

endmodule : tick_timer

/* File: hw/fet_sync_ctrl.sv */
// Sync-line state machine, FET driver control and register slave of the parallel FET controller.
`timescale 1ns/1ns
`include "fet_sync_regs.svh"

module fet_sync_ctrl #(
  parameter logic [6:0]           TICK_CYC  = 7'(`TICK_CYC),
  parameter fet_sync_pkg::tcount_t INSERT_T = `INSERT_TICKS,
  parameter fet_sync_pkg::tcount_t RETRY_T  = `RETRY_TICKS,
  parameter fet_sync_pkg::tcount_t FT_OFF_T = `FT_OFF_TICKS,
  parameter fet_sync_pkg::tcount_t FT_ON_T  = `FT_ON_TICKS
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output wire logic                  hreadyout,
  output wire logic [31:0]           hrdata,
  output wire logic                  hresp,
  input  wire logic                  general_io_three_in,
  output wire logic                  general_io_three_out,
  output wire logic                  general_io_three_oe,
  input  wire fet_sync_pkg::cond_t   cond_pins,
  output wire logic                  fet_driver_on,
  output wire logic [7:0]            current_reference_setting,
  output wire logic                  current_limited_start,
  output wire logic                  current_sharing_on
);
  import fet_sync_pkg::*;

  main_state_t r;
  main_state_t n;
  logic        t_start;
  tcount_t     t_load;
  logic        sync_func;
  logic        line_high;
  logic        on_state;

  timer_if tmr ();

  tick_timer u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tmr     (tmr.cnt)
  );

  assign tmr.start = t_start;
  assign tmr.load  = t_load;
  assign tmr.tick  = r.tick;

  // ---------------------------------------------------------------------------
  // Line and state decode
  // ---------------------------------------------------------------------------

  // With the pin given another function the device runs standalone and sees the line as high.
  assign sync_func = (r.ctrl[`CTRL_GIO3_FUNC] == 1'b0);
  assign line_high = sync_func ? r.gio_s2 : 1'b1;
  assign on_state  = (r.state == ST_INRUSH) || (r.state == ST_STEADY) ||
                     (r.state == ST_OC_BLANK) || (r.state == ST_FT_ON);

  // Tells whether a state wants the pass FET on.
  function automatic logic wants_on(input state_t s);
    wants_on = (s == ST_INRUSH) || (s == ST_STEADY) || (s == ST_OC_BLANK) || (s == ST_FT_ON);
  endfunction : wants_on

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------

  // Fills the next copy of all state: synchronisers, divider, sequencer, outputs and registers.
  always_comb begin
    logic trip;
    trip    = 1'b0;
    n       = r;
    t_start = 1'b0;
    t_load  = 16'h0000;

    // Pin levels pass two flip-flops before anything reads them.
    n.cond_s1 = cond_pins;
    n.cond_s2 = r.cond_s1;
    n.gio_s1  = general_io_three_in;
    n.gio_s2  = r.gio_s1;

    // Divider that makes the one-cycle timer tick.
    n.tick = (r.div == 7'h00);
    n.div  = (r.div == 7'h00) ? (TICK_CYC - 7'h01) : (r.div - 7'h01);

    // Supply collapse or enable shutdown wins over everything and clears every latch.
    if (r.cond_s2[`C_EN_SD] || r.cond_s2[`C_VDD_UV]) begin
      n.state = ST_OFF;
    end else if ((r.state == ST_LATCH) || (r.state == ST_EXT_LATCH)) begin
      n.state = r.state;
    end else if (!r.cond_s2[`C_EN_OK] || r.cond_s2[`C_VIN_UV] || r.cond_s2[`C_VIN_OV]) begin
      n.state = ST_OFF;
    end else if (r.cond_s2[`C_OVERTEMP] || r.cond_s2[`C_HEALTH]) begin
      trip = 1'b1;
    end else if (on_state && r.seen_high && !line_high) begin
      n.state = ST_EXT_LATCH;
    end else if (on_state && r.cond_s2[`C_FAST_TRIP]) begin
      if (r.ctrl[`CTRL_ONESHOT] || r.ctrl[`CTRL_FAST_RECOV]) begin
        n.state = ST_FT_OFF;
        t_start = 1'b1;
        t_load  = FT_OFF_T;
      end else begin
        trip = 1'b1;
      end
    end else begin
      unique case (r.state)
        ST_OFF: begin
          n.state = ST_INSERT;
          t_start = 1'b1;
          t_load  = INSERT_T;
        end
        ST_INSERT: begin
          if (tmr.done) begin
            n.state = ST_INRUSH;
          end
        end
        ST_INRUSH: begin
          // The FET waits for the whole chain to let the line rise before inrush counts.
          if (r.cond_s2[`C_INRUSH_DONE] && line_high) begin
            n.state = ST_STEADY;
          end
        end
        ST_STEADY: begin
          if (r.cond_s2[`C_OVERCURRENT]) begin
            n.state = ST_OC_BLANK;
            t_start = 1'b1;
            t_load  = {8'h00, r.blank};
          end
        end
        ST_OC_BLANK: begin
          if (!r.cond_s2[`C_OVERCURRENT]) begin
            n.state = ST_STEADY;
          end else if (tmr.done) begin
            trip = 1'b1;
          end
        end
        ST_FT_OFF: begin
          if (tmr.done) begin
            if (r.ctrl[`CTRL_ONESHOT]) begin
              n.state = ST_FT_ON;
              t_start = 1'b1;
              t_load  = FT_ON_T;
            end else begin
              n.state  = ST_INRUSH;
              n.climit = 1'b1;
            end
          end
        end
        ST_FT_ON: begin
          if (tmr.done) begin
            n.state = ST_STEADY;
          end
        end
        ST_RETRY: begin
          if (tmr.done) begin
            n.state = ST_OFF;
          end
        end
        ST_LATCH, ST_EXT_LATCH: begin
          n.state = r.state;
        end
        default: begin
          n.state = ST_OFF;
        end
      endcase
    end

    // A persistent fault either waits out the retry timer or latches off.
    if (trip) begin
      if (r.ctrl[`CTRL_AUTO_RETRY]) begin
        n.state = ST_RETRY;
        t_start = 1'b1;
        t_load  = RETRY_T;
      end else begin
        n.state = ST_LATCH;
      end
    end

    // A line seen high while on arms external fault detection; leaving the on states disarms it.
    if (!on_state) begin
      n.seen_high = 1'b0;
    end else if (line_high) begin
      n.seen_high = 1'b1;
    end

    // Current-limited start only follows a fast recovery and ends in steady state or off.
    if ((n.state == ST_STEADY) || (n.state == ST_OFF)) begin
      n.climit = 1'b0;
    end

    // The line is only ever pulled low; release lets the outside pull-up lift it.
    n.gio_out = 1'b0;
    if (sync_func) begin
      n.pull_oe = !wants_on(n.state);
    end else begin
      n.pull_oe = !r.ctrl[`CTRL_GIO3_VAL];
    end

    // The driver is on only while the state wants it and the shared line is high, or the pin has another function.
    n.fet_on = wants_on(n.state) && line_high;

    // Sharing runs in steady state above the device threshold, below the system breaker level.
    n.acs = (r.state == ST_STEADY) && r.cond_s2[`C_OVER_SHARE] && !r.cond_s2[`C_SYS_OCP];

    // Data phase of a write stores into the addressed register.
    if (r.wr_pend) begin
      unique case (r.addr)
        `OFS_CTRL:   n.ctrl   = hwdata[`CTRL_W-1:0];
        `OFS_BLANK:  n.blank  = hwdata[7:0];
        `OFS_CURREF: n.curref = hwdata[7:0];
        default:     n.addr   = r.addr;
      endcase
    end

    // Address phase: latch writes, prepare read data from the updated copy.
    n.wr_pend = 1'b0;
    n.rdata   = 32'h0000_0000;
    n.ready   = 1'b1;
    if (hsel && hready && htrans[1]) begin
      n.addr    = haddr[7:0];
      n.wr_pend = hwrite && (haddr[31:8] == 24'h00_0000);
      if (!hwrite && (haddr[31:8] == 24'h00_0000)) begin
        unique case (haddr[7:0])
          `OFS_CTRL:   n.rdata = {18'h0_0000, n.ctrl};
          `OFS_BLANK:  n.rdata = {24'h00_0000, n.blank};
          `OFS_CURREF: n.rdata = {24'h00_0000, n.curref};
          `OFS_STATUS: n.rdata = {22'h0_0000, r.gio_s2, r.acs, (r.state == ST_EXT_LATCH),
                                  line_high, r.fet_on, r.climit, r.state};
          default:     n.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------

  // Reset holds the driver off, pulls the line low and gives the pin its sync function.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r         <= '0;
      r.state   <= ST_OFF;
      r.pull_oe <= 1'b1;
      r.ctrl    <= `CTRL_RESET;
      r.blank   <= `BLANK_RESET;
      r.curref  <= `CURREF_RESET;
      r.ready   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register, except hresp, which is tied to zero.
  assign hreadyout                 = r.ready;
  assign hrdata                    = r.rdata;
  assign hresp                     = 1'b0;
  assign general_io_three_out      = r.gio_out;
  assign general_io_three_oe       = r.pull_oe;
  assign fet_driver_on             = r.fet_on;
  assign current_reference_setting = r.curref;
  assign current_limited_start     = r.climit;
  assign current_sharing_on        = r.acs;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_release_when_on;
    sync_func && wants_on(r.state) |-> !r.pull_oe;
  endproperty
  a_release_when_on: assert property (p_release_when_on) else $error("Line pulled while FET wanted on.");

  property p_low_line_off;
    sync_func && !line_high |=> !r.fet_on;
  endproperty
  a_low_line_off: assert property (p_low_line_off) else $error("FET on while sync line low.");

  property p_steady_on;
    (r.state == ST_STEADY) && line_high && !r.cond_s2[`C_EN_SD] && !r.cond_s2[`C_VDD_UV] &&
      r.cond_s2[`C_EN_OK] && !r.cond_s2[`C_VIN_UV] && !r.cond_s2[`C_VIN_OV] &&
      !r.cond_s2[`C_OVERTEMP] && !r.cond_s2[`C_HEALTH] && !r.cond_s2[`C_FAST_TRIP] |=> r.fet_on;
  endproperty
  a_steady_on: assert property (p_steady_on) else $error("Driver dropped in steady state.");

  property p_retry_off;
    (r.state == ST_RETRY) && sync_func |-> r.pull_oe ##1 !r.fet_on;
  endproperty
  a_retry_off: assert property (p_retry_off) else $error("Retry wait with FET on or line free.");

  property p_ext_fault;
    on_state && r.seen_high && !line_high && !r.cond_s2[`C_EN_SD] && !r.cond_s2[`C_VDD_UV] &&
      r.cond_s2[`C_EN_OK] && !r.cond_s2[`C_VIN_UV] && !r.cond_s2[`C_VIN_OV] &&
      !r.cond_s2[`C_OVERTEMP] && !r.cond_s2[`C_HEALTH] |=> (r.state == ST_EXT_LATCH) ##1 r.pull_oe;
  endproperty
  a_ext_fault: assert property (p_ext_fault) else $error("External pull-down not latched.");

  property p_ext_hold;
    (r.state == ST_EXT_LATCH) && !r.cond_s2[`C_EN_SD] && !r.cond_s2[`C_VDD_UV] |=>
      (r.state == ST_EXT_LATCH) && !r.fet_on;
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("External fault latch released early.");

  property p_shutdown_clears;
    r.cond_s2[`C_EN_SD] |=> (r.state == ST_OFF);
  endproperty
  a_shutdown_clears: assert property (p_shutdown_clears) else $error("Shutdown did not clear state.");

  property p_oneshot_on;
    (r.state == ST_FT_OFF) && tmr.done && r.ctrl[`CTRL_ONESHOT] && !r.cond_s2[`C_EN_SD] &&
      !r.cond_s2[`C_VDD_UV] && r.cond_s2[`C_EN_OK] && !r.cond_s2[`C_VIN_UV] &&
      !r.cond_s2[`C_VIN_OV] && !r.cond_s2[`C_OVERTEMP] && !r.cond_s2[`C_HEALTH] |=> (r.state == ST_FT_ON);
  endproperty
  a_oneshot_on: assert property (p_oneshot_on) else $error("One-shot skipped its on phase.");

  property p_curref_write;
    r.wr_pend && (r.addr == `OFS_CURREF) |=> (current_reference_setting == $past(hwdata[7:0]));
  endproperty
  a_curref_write: assert property (p_curref_write) else $error("Reference write not applied.");

  property p_acs_engage;
    (r.state == ST_STEADY) && r.cond_s2[`C_OVER_SHARE] && !r.cond_s2[`C_SYS_OCP] |=> current_sharing_on;
  endproperty
  a_acs_engage: assert property (p_acs_engage) else $error("Sharing did not engage.");

  property p_acs_release;
    r.cond_s2[`C_SYS_OCP] |=> !current_sharing_on;
  endproperty
  a_acs_release: assert property (p_acs_release) else $error("Sharing stayed on above breaker level.");

endmodule : fet_sync_ctrl

/* File: testbench/secondary_model.sv */
// Behavioural secondary device that shares the open-drain sync line.
`timescale 1ns/1ns

module secondary_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic fault_req,
  input  wire logic sync_line,
  output logic      pull_oe,
  output logic      line_on
);
  // ----------------------------------------
  // Pull-down control
  // ----------------------------------------
  // A fault or turn-on blocker is reported only by pulling the line low, never by driving high.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pull_oe <= 1'b0;
    end else begin
      pull_oe <= fault_req;
    end
  end
  // The secondary switches its own FET from the line level that the primary commands.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_on <= 1'b0;
    end else begin
      line_on <= sync_line;
    end
  end
endmodule : secondary_model

/* File: testbench/tb.sv */
// Self-checking bench for the sync-line controller with one secondary on the line.
`timescale 1ns/1ns
`include "fet_sync_regs.svh"

module tb;
  import fet_sync_pkg::*;
  logic hclk, hresetn, hsel, hwrite, sec_fault, gio_out, gio_oe, fet_on, cls, acs, sec_oe, hresp, sec_on;
  logic [31:0] haddr, hwdata, hrdata, rd, wv;
  // Reference model of the current reference register: values written and not yet read back.
  int          ref_q[$];
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  curref;
  wire  logic  hready;
  cond_t       cond;
  int          bad_count, comparisons, cycles, seed, i;
  int          faults[$] = '{`C_VIN_UV, `C_VDD_UV, `C_VIN_OV, `C_OVERTEMP, `C_HEALTH, `C_FAST_TRIP, `C_OVERCURRENT};
  localparam cond_t RUN = cond_t'((1 << `C_EN_OK) | (1 << `C_INRUSH_DONE));
  // Pull-up wins unless any party pulls the line low.
  wire logic   line = !(gio_oe | sec_oe);

  fet_sync_ctrl #(.TICK_CYC(7'd4), .INSERT_T(16'h0002), .RETRY_T(16'h0002), .FT_OFF_T(16'h0002),
    .FT_ON_T(16'h0002)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata),
    .hresp(hresp), .general_io_three_in(line), .general_io_three_out(gio_out), .general_io_three_oe(gio_oe),
    .cond_pins(cond), .fet_driver_on(fet_on), .current_reference_setting(curref),
    .current_limited_start(cls), .current_sharing_on(acs));
  secondary_model i_sec (.hclk(hclk), .hresetn(hresetn), .fault_req(sec_fault), .sync_line(line),
    .pull_oe(sec_oe), .line_on(sec_on));

  // ----------------------------------------
  // Clock and timeout
  // ----------------------------------------
  // Free-running 100 MHz clock.
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Cuts a hang short.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      final_report();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    check(hresp, 1'b0);
  endtask : bus
  // Changes the condition pins just after a rising edge.
  task automatic set_cond(input cond_t c);
    @(posedge hclk);
    cond <= c;
  endtask : set_cond
  // Waits under a bound for the FET driver (sel 0) or sharing (sel 1) to reach a level.
  task automatic wait_lvl(input int sel, input logic v);
    int n;
    n = 0;
    while (((sel == 0) ? fet_on : acs) !== v && n < 300) begin
      @(posedge hclk);
      n++;
    end
    #1;
    check(((sel == 0) ? fet_on : acs), v);
  endtask : wait_lvl
  // Shutdown pulse on enable clears any latched off state, then powers up again.
  task automatic restart();
    @(posedge hclk);
    cond <= cond_t'(1 << `C_EN_SD);
    repeat (6) @(posedge hclk);
    cond <= RUN;
    wait_lvl(0, 1'b1);
    check(gio_oe, 1'b0);
    check(sec_on, 1'b1);
    check(gio_out, 1'b0);
  endtask : restart
  task automatic final_report();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h5588;
    hresetn = 1'b0; hsel = 1'b1; haddr = '0; htrans = '0; hwrite = 1'b0; hsize = 3'b010;
    hwdata = '0; cond = '0; sec_fault = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    check(gio_oe, 1'b1);
    check(fet_on, 1'b0);
    bus(1'b0, `OFS_CTRL, 0); check(rd, 32'h0000_0000);
    bus(1'b0, `OFS_BLANK, 0); check(rd, 32'h0000_0010);
    bus(1'b0, 32'h0000_0040, 0); check(rd, 32'h0000_0000);
    bus(1'b1, `OFS_CTRL, 32'h0000_0003);
    @(posedge hclk);
    #1;
    check(gio_oe, 1'b0);
    bus(1'b1, `OFS_CTRL, 32'h0000_0001);
    @(posedge hclk);
    #1;
    check(gio_oe, 1'b1);
    bus(1'b1, `OFS_CTRL, 32'h0000_0000);
    for (i = 0; i < 4; i++) begin
      wv = $random(seed);
      ref_q.push_back(int'(wv[7:0]));
      bus(1'b1, `OFS_CURREF, wv);
      #1;
      check(curref, ref_q[0]);
      bus(1'b0, `OFS_CURREF, 0);
      check(rd, ref_q.pop_front());
    end
    $display("test registers done");
    restart();
    // Each device-side fault must switch off and pull the line.
    foreach (faults[k]) begin
      set_cond(RUN | cond_t'(1 << faults[k]));
      wait_lvl(0, 1'b0);
      check(gio_oe, 1'b1);
      check(sec_on, 1'b0);
      set_cond(RUN);
      restart();
    end
    $display("test faults done");
    sec_fault <= 1'b1;
    wait_lvl(0, 1'b0);
    check(gio_oe, 1'b1);
    sec_fault <= 1'b0;
    repeat (20) @(posedge hclk);
    #1; check(gio_oe, 1'b1);
    check(fet_on, 1'b0);
    bus(1'b0, `OFS_STATUS, 0); check(rd[3:0], 4'h9);
    restart();
    $display("test external fault done");
    bus(1'b1, `OFS_CTRL, 32'h0000_2000);
    set_cond(RUN | cond_t'(1 << `C_FAST_TRIP));
    wait_lvl(0, 1'b0);
    check(gio_oe, 1'b1);
    set_cond(RUN);
    wait_lvl(0, 1'b1);
    check(gio_oe, 1'b0);
    bus(1'b1, `OFS_CTRL, 32'h0000_0008);
    set_cond(RUN | cond_t'(1 << `C_FAST_TRIP));
    wait_lvl(0, 1'b0);
    // Inrush is held open so the current-limited restart is seen while the driver is on.
    set_cond(cond_t'(1 << `C_EN_OK));
    wait_lvl(0, 1'b1);
    check(cls, 1'b1);
    set_cond(RUN);
    $display("test fast trip done");
    repeat (20) @(posedge hclk);
    #1;
    check(cls, 1'b0);
    set_cond(RUN | cond_t'(1 << `C_OVER_SHARE));
    wait_lvl(1, 1'b1);
    check(fet_on, 1'b1);
    set_cond(RUN | cond_t'((1 << `C_OVER_SHARE) | (1 << `C_SYS_OCP)));
    wait_lvl(1, 1'b0);
    $display("test sharing done");
    // With auto-retry the device comes back by itself once the fault is gone.
    bus(1'b1, `OFS_CTRL, 32'h0000_0004);
    set_cond(RUN | cond_t'(1 << `C_OVERTEMP));
    wait_lvl(0, 1'b0);
    check(gio_oe, 1'b1);
    set_cond(RUN);
    wait_lvl(0, 1'b1);
    check(gio_oe, 1'b0);
    $display("test retry done");
    final_report();
  end
endmodule : tb
